// ### design/duhp_pkg.sv
package duhp_pkg;

  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int unsigned CLK_NS        = 40;
  localparam int unsigned HW_RST_MIN_NS = 40;
  // The pulse must be longer than the minimum, hence one sample beyond the rounded-up count.
  localparam int unsigned HW_RST_CYC    = (HW_RST_MIN_NS + CLK_NS - 1) / CLK_NS + 1;
  localparam int unsigned RST_CNT_W     = 2;
  localparam logic [RST_CNT_W-1:0] RST_FIRE = RST_CNT_W'(HW_RST_CYC - 1);

  // ==========================================================================
  // Register locations and fields
  // ==========================================================================
  localparam logic [2:0] A_DATA = 3'h0;
  localparam logic [2:0] A_IER  = 3'h1;
  localparam logic [2:0] A_FCR  = 3'h2;
  localparam logic [2:0] A_LCR  = 3'h3;
  localparam logic [2:0] A_MCR  = 3'h4;
  localparam logic [2:0] A_LSR  = 3'h5;
  localparam logic [2:0] A_MSR  = 3'h6;
  localparam logic [2:0] A_SPR  = 3'h7;
  localparam int unsigned LCR_DLAB  = 7;
  localparam int unsigned FCR_EN    = 0;
  localparam int unsigned FCR_RXRST = 1;
  localparam int unsigned FCR_TXRST = 2;
  localparam int unsigned FCR_TXT   = 4;
  localparam int unsigned FCR_RXT   = 6;
  localparam int unsigned MCR_DTR   = 0;
  localparam int unsigned MCR_RTS   = 1;
  localparam int unsigned IER_RX    = 0;
  localparam int unsigned IER_TX    = 1;
  localparam logic [3:0] ISR_NONE = 4'h1;
  localparam logic [3:0] ISR_TX   = 4'h2;
  localparam logic [3:0] ISR_RX   = 4'h4;
  localparam logic [7:0] DLL_RST  = 8'h01;
  localparam logic [6:0] CAP_FIFO = 7'h40;
  localparam logic [6:0] CAP_ONE  = 7'h01;
  localparam logic [3:0][6:0] RX_TRIG = {7'h3C, 7'h38, 7'h10, 7'h08};
  localparam logic [3:0][6:0] TX_TRIG = {7'h38, 7'h20, 7'h10, 7'h08};

  // ==========================================================================
  // Types
  // ==========================================================================
  typedef enum logic [1:0] {
    BS_IDLE = 2'b00,
    BS_RD   = 2'b01,
    BS_WR   = 2'b10
  } duhp_bus_st_t;

  typedef struct packed {
    logic [3:0]  ier;
    logic [7:0]  lcr;
    logic [7:0]  mcr;
    logic [7:0]  spr;
    logic [7:0]  dll;
    logic [7:0]  divisor_high_byte;
    logic        fifo_en;
    logic [1:0]  rx_trig;
    logic [1:0]  tx_trig;
    logic [6:0]  tx_lvl;
    logic [6:0]  rx_lvl;
    logic [7:0]  rx_byte;
    logic [15:0] baud_cnt;
    logic        baud_tick;
    logic        rts_n;
    logic        dtr_n;
  } duhp_chan_st_t;

  localparam duhp_chan_st_t CHAN_RST = '{default: '0, dll: DLL_RST, rts_n: 1'b1, dtr_n: 1'b1};

  typedef struct packed {
    duhp_bus_st_t         bus_st;
    logic [1:0]           sel;
    logic [2:0]           addr;
    logic [7:0]           wdata;
    logic [1:0]           wr_p;
    logic [1:0]           pop_p;
    logic [7:0]           data_out;
    logic                 data_oe;
    logic                 osc_q;
    logic [RST_CNT_W-1:0] rst_cnt;
    logic                 hw_rst_act;
    logic [1:0]           int_pin;
  } duhp_top_st_t;

endpackage

// ### design/duhp_chan.sv
`timescale 1ns/1ns
`default_nettype none
module duhp_chan
  import duhp_pkg::*;
#(
  parameter logic [7:0] DEV_ID = 8'h5A, // Arbitrary value.
  parameter logic [7:0] REV_ID = 8'h3C  // Arbitrary value.
) (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       wr_en,
  input  wire logic       rd_pop,
  input  wire logic [2:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       osc_tick,
  input  wire logic       rx_valid,
  input  wire logic [7:0] rx_data,
  output logic      [7:0] rdata,
  output logic            irq_cond,
  output logic            baud_tick,
  output logic            rts_n,
  output logic            dtr_n
);

  // ==========================================================================
  // State
  // ==========================================================================
  duhp_chan_st_t s_r;
  duhp_chan_st_t s_nxt;
  logic          dlab;
  logic          id_zero;
  logic [6:0]    cap;
  logic          tx_int;
  logic          rx_int;
  logic          tx_push;
  logic          tx_pop;
  logic          rx_push;
  logic          rx_pop;

  // Decode helpers shared by the register file and the FIFO level counters.
  assign dlab    = s_r.lcr[LCR_DLAB];
  assign id_zero = (s_r.dll == 8'h00) && (s_r.divisor_high_byte == 8'h00);
  assign cap     = s_r.fifo_en ? CAP_FIFO : CAP_ONE;
  assign tx_push = wr_en && (addr == A_DATA) && !dlab && (s_r.tx_lvl < cap);
  assign tx_pop  = s_r.baud_tick && (s_r.tx_lvl != 7'h00);
  assign rx_push = rx_valid && (s_r.rx_lvl < cap);
  assign rx_pop  = rd_pop && (addr == A_DATA) && !dlab && (s_r.rx_lvl != 7'h00);

  // Interrupt conditions follow the FIFO enable; trigger compares are inclusive.
  assign tx_int   = s_r.fifo_en ? (s_r.tx_lvl <= TX_TRIG[s_r.tx_trig]) : (s_r.tx_lvl == 7'h00);
  assign rx_int   = s_r.fifo_en ? (s_r.rx_lvl >= RX_TRIG[s_r.rx_trig]) : (s_r.rx_lvl != 7'h00);
  assign irq_cond = (rx_int && s_r.ier[IER_RX]) || (tx_int && s_r.ier[IER_TX]);
  assign baud_tick = s_r.baud_tick;
  assign rts_n     = s_r.rts_n;
  assign dtr_n     = s_r.dtr_n;

  // Read mux over the eight locations; the divisor pair reads identity codes when both are zero.
  always_comb begin
    rdata = 8'h00;
    unique case (addr)
      A_DATA: rdata = dlab ? (id_zero ? REV_ID : s_r.dll) : s_r.rx_byte;
      A_IER:  rdata = dlab ? (id_zero ? DEV_ID : s_r.divisor_high_byte) : {4'h0, s_r.ier};
      A_FCR:  rdata = {s_r.fifo_en, s_r.fifo_en, 2'b00, rx_int ? ISR_RX : (tx_int ? ISR_TX : ISR_NONE)};
      A_LCR:  rdata = s_r.lcr;
      A_MCR:  rdata = s_r.mcr;
      A_LSR:  rdata = {1'b0, s_r.tx_lvl == 7'h00, s_r.tx_lvl == 7'h00, 4'h0, s_r.rx_lvl != 7'h00};
      A_MSR:  rdata = 8'h00;
      A_SPR:  rdata = s_r.spr;
    endcase
  end

  // ==========================================================================
  // Next state: baud divider, levels, register writes
  // ==========================================================================
  always_comb begin
    s_nxt = s_r;
    s_nxt.baud_tick = 1'b0;
    // The divider counts rising oscillator edges only, never the host strobes.
    if (osc_tick) begin
      if (s_r.baud_cnt <= 16'h0001) begin
        s_nxt.baud_cnt  = {s_r.divisor_high_byte, s_r.dll};
        s_nxt.baud_tick = 1'b1;
      end else begin
        s_nxt.baud_cnt = s_r.baud_cnt - 16'h0001;
      end
    end
    if (tx_push && !tx_pop) begin
      s_nxt.tx_lvl = s_r.tx_lvl + 7'h01;
    end else if (tx_pop && !tx_push) begin
      s_nxt.tx_lvl = s_r.tx_lvl - 7'h01;
    end
    if (rx_push) begin
      s_nxt.rx_byte = rx_data;
    end
    if (rx_push && !rx_pop) begin
      s_nxt.rx_lvl = s_r.rx_lvl + 7'h01;
    end else if (rx_pop && !rx_push) begin
      s_nxt.rx_lvl = s_r.rx_lvl - 7'h01;
    end
    if (wr_en) begin
      unique case (addr)
        A_DATA: begin
          if (dlab) begin
            s_nxt.dll = wdata;
          end
        end
        A_IER: begin
          if (dlab) begin
            s_nxt.divisor_high_byte = wdata;
          end else begin
            s_nxt.ier = wdata[3:0];
          end
        end
        A_FCR: begin
          // Block-transfer bit 3 is deliberately not decoded.
          s_nxt.fifo_en = wdata[FCR_EN];
          s_nxt.rx_trig = wdata[FCR_RXT +: 2];
          s_nxt.tx_trig = wdata[FCR_TXT +: 2];
          // Toggling the FIFO mode flushes both sides so the one-byte limit cannot be exceeded.
          if (wdata[FCR_RXRST] || (wdata[FCR_EN] != s_r.fifo_en)) begin
            s_nxt.rx_lvl = 7'h00;
          end
          if (wdata[FCR_TXRST] || (wdata[FCR_EN] != s_r.fifo_en)) begin
            s_nxt.tx_lvl = 7'h00;
          end
        end
        A_LCR: s_nxt.lcr = wdata;
        A_MCR: begin
          s_nxt.mcr   = wdata;
          s_nxt.rts_n = ~wdata[MCR_RTS];
          s_nxt.dtr_n = ~wdata[MCR_DTR];
        end
        A_LSR, A_MSR: begin
        end
        A_SPR: s_nxt.spr = wdata;
      endcase
    end
  end

  // Registers and serial-side outputs return to defaults on either reset.
  always_ff @(posedge clk) begin
    if (rst) begin
      s_r <= CHAN_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ==========================================================================
  // Checks
  // ==========================================================================
  a_id_read: assert property (@(posedge clk) disable iff (rst)
    (dlab && id_zero && (addr == A_IER)) |-> (rdata == DEV_ID))
    else $error("identity code not returned");
  a_tx_int_off: assert property (@(posedge clk) disable iff (rst)
    (wr_en && (addr == A_DATA) && !dlab && !s_r.fifo_en) |=> !tx_int)
    else $error("transmit condition stayed with a byte held");
  a_rx_int_on: assert property (@(posedge clk) disable iff (rst)
    (rx_valid && !s_r.fifo_en && !wr_en && !rd_pop) |=> rx_int)
    else $error("receive condition missing after a byte");
  a_tx_trig_hi: assert property (@(posedge clk) disable iff (rst)
    (s_r.fifo_en && (s_r.tx_lvl > TX_TRIG[s_r.tx_trig])) |-> !tx_int)
    else $error("transmit condition above trigger");

endmodule
`default_nettype wire

// ### design/duhp_top.sv
`timescale 1ns/1ns
`default_nettype none
// Function
// - Eight-bit data, three address lines, read/write.
// - Bus cycles timed only by selects and strobes.
// - Hardware reset restores registers and serial outputs.
// - Zero divisor: high reads identity, low revision.
// - Strobe mode: each select low picks its channel.
// - Both selects low broadcast writes; never read.
// - Direction mode: chip select, fourth address picks.
// - Fourth address ignored outside direction mode.
// - Block-transfer bit has no effect.
// - Interrupt pin polarity follows bus type.
// - FIFO on: transmit condition at or below trigger.
// - Receive condition: byte present or trigger reached.
// - Oscillator clocks baud generators, buffered copy out.
// - Direction mode uses chip select, direction and fourth address only.
module duhp_top
  import duhp_pkg::*;
#(
  parameter int unsigned DATA_W = 8,
  parameter int unsigned ADDR_W = 3,
  parameter logic [7:0]  DEV_ID = 8'h5A, // Arbitrary value.
  parameter logic [7:0]  REV_ID = 8'h3C  // Arbitrary value.
) (
  input  wire logic              clk,
  input  wire logic              sys_rst,
  input  wire logic              bus_type,
  input  wire logic              chan_a_select_n,
  input  wire logic              chan_b_select_n,
  input  wire logic              chip_select_n,
  input  wire logic              read_strobe_n,
  input  wire logic              write_strobe_n,
  input  wire logic              rw_dir,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic              addr3,
  input  wire logic [DATA_W-1:0] data_in,
  output logic      [DATA_W-1:0] data_out,
  output logic                   data_oe,
  input  wire logic              hw_reset,
  input  wire logic              osc_in,
  output logic                   osc_buffered_out,
  input  wire logic              rx_valid_a,
  input  wire logic [DATA_W-1:0] rx_data_a,
  input  wire logic              rx_valid_b,
  input  wire logic [DATA_W-1:0] rx_data_b,
  output logic                   int_a,
  output logic                   int_b,
  output logic                   rts_a_n,
  output logic                   rts_b_n,
  output logic                   dtr_a_n,
  output logic                   dtr_b_n,
  output logic                   baud_tick_a,
  output logic                   baud_tick_b
);

  // ==========================================================================
  // Elaboration checks
  // ==========================================================================
  if ((DATA_W != 8) || (ADDR_W != 3)) begin : g_bad_width
    $error("duhp_top supports only an 8-bit bus with three address lines");
  end

  // ==========================================================================
  // Decode
  // ==========================================================================
  duhp_top_st_t t_r;
  duhp_top_st_t t_nxt;
  logic [1:0]   sel_now;
  logic         rd_now;
  logic         wr_now;
  logic         rd_any;
  logic         wr_any;
  logic         osc_tick;
  logic         chan_rst;
  logic [2:0]   chan_addr;
  logic [1:0]   irq;
  logic [1:0]   rts_w;
  logic [1:0]   dtr_w;
  logic [1:0]   tick_w;
  logic [1:0]   rx_v;
  logic [7:0]   rx_d    [2];
  logic [7:0]   rdata_w [2];

  // Channel select and direction by bus type; the fourth address only counts in direction mode.
  assign sel_now = bus_type ? {~chan_b_select_n, ~chan_a_select_n}
                            : {~chip_select_n & addr3, ~chip_select_n & ~addr3};
  // The read strobe is not looked at in direction mode.
  assign rd_now  = bus_type ? ~read_strobe_n : rw_dir;
  assign wr_now  = bus_type ? ~write_strobe_n : ~rw_dir;
  // A read with both channels selected is never served, so the bus stays undriven.
  assign rd_any  = (sel_now != 2'b00) && (sel_now != 2'b11) && rd_now;
  assign wr_any  = (sel_now != 2'b00) && wr_now && !rd_now;
  assign osc_tick = osc_in && !t_r.osc_q;
  assign chan_rst = sys_rst || t_r.hw_rst_act;
  // Latched address is used while a cycle or its closing pulse is in flight.
  assign chan_addr = ((t_r.bus_st != BS_IDLE) || (t_r.wr_p != 2'b00) || (t_r.pop_p != 2'b00)) ? t_r.addr : addr;
  assign rx_v    = {rx_valid_b, rx_valid_a};
  assign rx_d[0] = rx_data_a;
  assign rx_d[1] = rx_data_b;

  // ==========================================================================
  // Channels
  // ==========================================================================
  for (genvar c = 0; c < 2; c++) begin : g_chan
    duhp_chan #(
      .DEV_ID (DEV_ID),
      .REV_ID (REV_ID)
    ) u_chan (
      .clk       (clk),
      .rst       (chan_rst),
      .wr_en     (t_r.wr_p[c]),
      .rd_pop    (t_r.pop_p[c]),
      .addr      (chan_addr),
      .wdata     (t_r.wdata),
      .osc_tick  (osc_tick),
      .rx_valid  (rx_v[c]),
      .rx_data   (rx_d[c]),
      .rdata     (rdata_w[c]),
      .irq_cond  (irq[c]),
      .baud_tick (tick_w[c]),
      .rts_n     (rts_w[c]),
      .dtr_n     (dtr_w[c])
    );
  end

  // ==========================================================================
  // Bus cycle tracking and pins
  // ==========================================================================
  // A cycle is committed when its strobe or direction condition goes away, not on any clock of the oscillator.
  always_comb begin
    t_nxt = t_r;
    t_nxt.wr_p  = 2'b00;
    t_nxt.pop_p = 2'b00;
    t_nxt.osc_q = osc_in;
    // Short reset pulses are filtered so glitches cannot wipe the channels.
    if (hw_reset) begin
      if (t_r.rst_cnt != RST_FIRE) begin
        t_nxt.rst_cnt = t_r.rst_cnt + RST_CNT_W'(1);
      end
    end else begin
      t_nxt.rst_cnt = '0;
    end
    t_nxt.hw_rst_act = hw_reset && (t_r.rst_cnt == RST_FIRE);
    unique case (t_r.bus_st)
      BS_IDLE: begin
        if (rd_any) begin
          t_nxt.bus_st = BS_RD;
          t_nxt.sel    = sel_now;
          t_nxt.addr   = addr;
        end else if (wr_any) begin
          t_nxt.bus_st = BS_WR;
          t_nxt.sel    = sel_now;
          t_nxt.addr   = addr;
          t_nxt.wdata  = data_in;
        end
      end
      BS_RD: begin
        if (!rd_any) begin
          t_nxt.bus_st = BS_IDLE;
          t_nxt.pop_p  = (t_r.addr == A_DATA) ? t_r.sel : 2'b00;
        end
      end
      BS_WR: begin
        if (wr_any) begin
          t_nxt.sel   = sel_now;
          t_nxt.addr  = addr;
          t_nxt.wdata = data_in;
        end else begin
          t_nxt.bus_st = BS_IDLE;
          t_nxt.wr_p   = t_r.sel;
        end
      end
    endcase
    // The data bus is enabled only while a single-channel read is in progress.
    t_nxt.data_oe = (t_nxt.bus_st == BS_RD);
    if (t_nxt.bus_st == BS_RD) begin
      t_nxt.data_out = t_nxt.sel[1] ? rdata_w[1] : rdata_w[0];
    end
    // Strobe bus is active high, direction bus active low.
    t_nxt.int_pin = bus_type ? irq : ~irq;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      t_r <= '{default: '0, bus_st: BS_IDLE};
    end else begin
      t_r <= t_nxt;
    end
  end

  assign data_out         = t_r.data_out;
  assign data_oe          = t_r.data_oe;
  assign osc_buffered_out = t_r.osc_q;
  assign int_a            = t_r.int_pin[0];
  assign int_b            = t_r.int_pin[1];
  assign rts_a_n          = rts_w[0];
  assign rts_b_n          = rts_w[1];
  assign dtr_a_n          = dtr_w[0];
  assign dtr_b_n          = dtr_w[1];
  assign baud_tick_a      = tick_w[0];
  assign baud_tick_b      = tick_w[1];

  // ==========================================================================
  // Checks
  // ==========================================================================
  a_oe_read_only: assert property (@(posedge clk) disable iff (sys_rst)
    data_oe |-> $past(rd_any))
    else $error("data bus driven outside a read");
  a_no_both_read: assert property (@(posedge clk) disable iff (sys_rst)
    (sel_now == 2'b11) |=> !data_oe)
    else $error("data bus driven with both channels selected");
  a_bcast_write: assert property (@(posedge clk) disable iff (sys_rst)
    ((t_r.bus_st == BS_WR) && !wr_any && (t_r.sel == 2'b11)) |=> (t_r.wr_p == 2'b11))
    else $error("broadcast write missed a channel");
  a_strobe_sel: assert property (@(posedge clk) disable iff (sys_rst)
    ((t_r.bus_st == BS_IDLE) && bus_type && !chan_a_select_n && chan_b_select_n && rd_now)
      |=> (t_r.sel == 2'b01) && (t_r.bus_st == BS_RD))
    else $error("strobe mode select wrong");
  a_dir_sel: assert property (@(posedge clk) disable iff (sys_rst)
    ((t_r.bus_st == BS_IDLE) && !bus_type && !chip_select_n && addr3 && rw_dir)
      |=> (t_r.sel == 2'b10) ##1 data_oe)
    else $error("direction mode select wrong");
  a_int_pol: assert property (@(posedge clk) disable iff (sys_rst)
    !$past(sys_rst) |-> (int_a == ($past(bus_type) ? $past(irq[0]) : !$past(irq[0]))))
    else $error("interrupt pin polarity wrong");
  a_hw_rst: assert property (@(posedge clk) disable iff (sys_rst)
    hw_reset [*2] |=> t_r.hw_rst_act ##1 (rts_a_n && dtr_b_n))
    else $error("long reset pulse not taken");
  a_short_rst: assert property (@(posedge clk) disable iff (sys_rst)
    (!hw_reset ##1 hw_reset ##1 !hw_reset) |=> !t_r.hw_rst_act)
    else $error("short reset pulse taken");
  a_osc_buf: assert property (@(posedge clk) disable iff (sys_rst)
    !$past(sys_rst) |-> (osc_buffered_out == $past(osc_in)))
    else $error("oscillator copy wrong");

endmodule
`default_nettype wire

// ### tb/duhp_host_model.sv
`timescale 1ns/1ns
`default_nettype none
// ==========================================================================
// Host processor model
// ==========================================================================
module duhp_host_model (
  input  wire logic       clk,
  input  wire logic       bus_type,
  output logic            chan_a_select_n,
  output logic            chan_b_select_n,
  output logic            chip_select_n,
  output logic            read_strobe_n,
  output logic            write_strobe_n,
  output logic            rw_dir,
  output logic [2:0]      addr,
  output logic            addr3,
  output logic [7:0]      data_in,
  input  wire logic [7:0] data_out,
  input  wire logic       data_oe
);
  logic [7:0] drv;
  logic [7:0] last_d;
  // The wire follows the device while it drives, else the host's own value.
  assign data_in = data_oe ? data_out : drv;
  // A released bus shows the inverse of the last byte, so stale data never matches by luck.
  initial begin
    {chan_a_select_n, chan_b_select_n, chip_select_n} = 3'h7;
    {read_strobe_n, write_strobe_n, rw_dir, addr3} = 4'hF;
    addr = 3'h0;
    last_d = 8'h00;
    drv = 8'hFF;
  end
  // Start a cycle after a falling edge; sel bit 0 is channel A, bit 1 channel B.
  task automatic go(input logic [1:0] sel, input logic [2:0] a, input logic rd, input logic [7:0] d);
    @(negedge clk);
    addr = a;
    drv = d;
    if (bus_type) begin
      addr3 = 1'b1;
      chan_a_select_n = ~sel[0];
      chan_b_select_n = ~sel[1];
      read_strobe_n = ~rd;
      write_strobe_n = rd;
    end else begin
      addr3 = sel[1];
      chip_select_n = 1'b0;
      rw_dir = rd;
    end
  endtask
  // Release selects, strobes and direction and leave an idle gap before the next cycle.
  task automatic stop();
    @(negedge clk);
    {chan_a_select_n, chan_b_select_n, chip_select_n} = 3'h7;
    {read_strobe_n, write_strobe_n, rw_dir} = 3'h7;
    drv = ~last_d;
    repeat (3) @(negedge clk);
  endtask
  // Write holds the request for a few cycles; broadcast is allowed.
  task automatic wr(input logic [1:0] sel, input logic [2:0] a, input logic [7:0] d);
    last_d = d;
    go(sel, a, 1'b0, d);
    repeat (2) @(negedge clk);
    stop();
  endtask
  // Read names one channel only and takes data once the device drives.
  task automatic rd(input logic [1:0] sel, input logic [2:0] a, output logic [7:0] d, output logic ok);
    ok = 1'b0;
    d = 8'h00;
    go(sel, a, 1'b1, ~last_d);
    for (int i = 0; i < 8 && !ok; i++) begin
      @(negedge clk);
      if (data_oe === 1'b1) begin
        d = data_out;
        ok = 1'b1;
      end
    end
    stop();
  endtask
endmodule
`default_nettype wire

// ### tb/dual_uart_host_bus_port_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
// ==========================================================================
// Testbench top
// ==========================================================================
module dual_uart_host_bus_port_tb_top;
  import duhp_pkg::*;
  // Identity values are arbitrary.
  localparam logic [7:0] ID_DEV = 8'h6B;
  localparam logic [7:0] ID_REV = 8'h2D;
  logic       clk, sys_rst, bus_type, hw_reset, osc_in, rx_valid_a, rx_valid_b;
  logic [7:0] rx_data_a, rx_data_b, data_in, data_out;
  logic       chan_a_select_n, chan_b_select_n, chip_select_n, read_strobe_n, write_strobe_n, rw_dir, addr3;
  logic [2:0] addr;
  logic       data_oe, osc_buffered_out, int_a, int_b, rts_a_n, rts_b_n, dtr_a_n, dtr_b_n;
  logic       baud_tick_a, baud_tick_b;
  int         mismatches;
  int         checks_done;
  int         ticks;
  int         ticks_b;

  duhp_top #(.DEV_ID(ID_DEV), .REV_ID(ID_REV)) i_dut (
    .clk(clk), .sys_rst(sys_rst), .bus_type(bus_type), .chan_a_select_n(chan_a_select_n),
    .chan_b_select_n(chan_b_select_n), .chip_select_n(chip_select_n), .read_strobe_n(read_strobe_n),
    .write_strobe_n(write_strobe_n), .rw_dir(rw_dir), .addr(addr), .addr3(addr3), .data_in(data_in),
    .data_out(data_out), .data_oe(data_oe), .hw_reset(hw_reset), .osc_in(osc_in),
    .osc_buffered_out(osc_buffered_out), .rx_valid_a(rx_valid_a), .rx_data_a(rx_data_a),
    .rx_valid_b(rx_valid_b), .rx_data_b(rx_data_b), .int_a(int_a), .int_b(int_b), .rts_a_n(rts_a_n),
    .rts_b_n(rts_b_n), .dtr_a_n(dtr_a_n), .dtr_b_n(dtr_b_n), .baud_tick_a(baud_tick_a),
    .baud_tick_b(baud_tick_b));

  duhp_host_model i_host (
    .clk(clk), .bus_type(bus_type), .chan_a_select_n(chan_a_select_n), .chan_b_select_n(chan_b_select_n),
    .chip_select_n(chip_select_n), .read_strobe_n(read_strobe_n), .write_strobe_n(write_strobe_n),
    .rw_dir(rw_dir), .addr(addr), .addr3(addr3), .data_in(data_in), .data_out(data_out), .data_oe(data_oe));

  // Free-running bus clock.
  always #20 clk = ~clk;

  // Compare one value and count the result.
  task automatic check(input string n, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", n, exp, seen);
    end
  endtask
  // Read through the host and compare; a read that never answers counts as a mismatch.
  task automatic hr(input string n, input logic [1:0] sel, input logic [2:0] a, input logic [7:0] exp);
    logic [7:0] d;
    logic       ok;
    i_host.rd(sel, a, d, ok);
    check({n, "_answered"}, {7'h00, ok}, 8'h01);
    check(n, d, exp);
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Main sequence; the oscillator stays still during bus tests, as bus cycles need only the bus clock.
  initial begin
    {clk, sys_rst, bus_type, hw_reset, osc_in, rx_valid_a, rx_valid_b} = 7'b0110000;
    {rx_data_a, rx_data_b} = 16'h0000;
    mismatches = 0;
    checks_done = 0;
    repeat (2) @(negedge clk);
    sys_rst = 1'b0;
    check("rts_a_n", {7'h00, rts_a_n}, 8'h01);
    check("data_oe", {7'h00, data_oe}, 8'h00);
    hr("spr_a", 2'b01, A_SPR, 8'h00);
    $display("test 1 done");
    i_host.wr(2'b01, A_SPR, 8'h55);
    hr("spr_a", 2'b01, A_SPR, 8'h55);
    hr("spr_b", 2'b10, A_SPR, 8'h00);
    i_host.wr(2'b11, A_SPR, 8'hA5);
    hr("spr_a", 2'b01, A_SPR, 8'hA5);
    hr("spr_b", 2'b10, A_SPR, 8'hA5);
    $display("test 2 done");
    bus_type = 1'b0;
    i_host.wr(2'b10, A_SPR, 8'h33);
    hr("spr_b", 2'b10, A_SPR, 8'h33);
    hr("spr_a", 2'b01, A_SPR, 8'hA5);
    bus_type = 1'b1;
    hr("spr_a", 2'b01, A_SPR, 8'hA5);
    $display("test 3 done");
    i_host.wr(2'b01, A_LCR, 8'h80);
    hr("dll_a", 2'b01, A_DATA, 8'h01);
    i_host.wr(2'b01, A_DATA, 8'h00);
    i_host.wr(2'b01, A_IER, 8'h00);
    hr("dev_id", 2'b01, A_IER, ID_DEV);
    hr("rev_id", 2'b01, A_DATA, ID_REV);
    i_host.wr(2'b01, A_LCR, 8'h00);
    $display("test 4 done");
    check("int_a", {7'h00, int_a}, 8'h00);
    i_host.wr(2'b01, A_IER, 8'h02);
    check("int_a", {7'h00, int_a}, 8'h01);
    bus_type = 1'b0;
    repeat (2) @(negedge clk);
    check("int_a", {7'h00, int_a}, 8'h00);
    check("int_b", {7'h00, int_b}, 8'h01);
    bus_type = 1'b1;
    // One byte held with the FIFO off must drop the transmit condition.
    i_host.wr(2'b01, A_DATA, 8'h7E);
    check("int_a", {7'h00, int_a}, 8'h00);
    i_host.wr(2'b01, A_IER, 8'h01);
    check("int_a", {7'h00, int_a}, 8'h00);
    rx_data_a = 8'hC3;
    rx_valid_a = 1'b1;
    @(negedge clk);
    rx_valid_a = 1'b0;
    repeat (3) @(negedge clk);
    check("int_a", {7'h00, int_a}, 8'h01);
    hr("rx_a", 2'b01, A_DATA, 8'hC3);
    check("int_a", {7'h00, int_a}, 8'h00);
    i_host.wr(2'b01, A_FCR, 8'h09);
    i_host.wr(2'b01, A_IER, 8'h02);
    check("int_a", {7'h00, int_a}, 8'h01);
    hr("isr_a", 2'b01, A_FCR, 8'hC2);
    // Nine bytes lift the transmit level above the lowest trigger of eight.
    for (int k = 0; k < 9; k++) i_host.wr(2'b01, A_DATA, 8'(k));
    check("int_a", {7'h00, int_a}, 8'h00);
    $display("test 5 done");
    i_host.wr(2'b11, A_MCR, 8'h03);
    check("rts_a_n", {7'h00, rts_a_n}, 8'h00);
    check("dtr_a_n", {7'h00, dtr_a_n}, 8'h00);
    check("rts_b_n", {7'h00, rts_b_n}, 8'h00);
    check("dtr_b_n", {7'h00, dtr_b_n}, 8'h00);
    // A single-cycle pulse is too short to count as a reset.
    hw_reset = 1'b1;
    @(negedge clk);
    hw_reset = 1'b0;
    repeat (2) @(negedge clk);
    check("rts_a_n", {7'h00, rts_a_n}, 8'h00);
    hw_reset = 1'b1;
    repeat (3) @(negedge clk);
    hw_reset = 1'b0;
    repeat (2) @(negedge clk);
    check("rts_a_n", {7'h00, rts_a_n}, 8'h01);
    check("dtr_a_n", {7'h00, dtr_a_n}, 8'h01);
    check("rts_b_n", {7'h00, rts_b_n}, 8'h01);
    check("dtr_b_n", {7'h00, dtr_b_n}, 8'h01);
    hr("spr_a", 2'b01, A_SPR, 8'h00);
    hr("spr_b", 2'b10, A_SPR, 8'h00);
    $display("test 6 done");
    ticks = 0;
    ticks_b = 0;
    for (int i = 0; i < 16; i++) begin
      osc_in = i[1];
      @(negedge clk);
      ticks += int'(baud_tick_a === 1'b1);
      ticks_b += int'(baud_tick_b === 1'b1);
      if (i == 3) check("osc_out", {7'h00, osc_buffered_out}, 8'h01);
      if (i == 5) check("osc_out", {7'h00, osc_buffered_out}, 8'h00);
    end
    osc_in = 1'b0;
    repeat (3) @(negedge clk);
    ticks += int'(baud_tick_a === 1'b1);
    ticks_b += int'(baud_tick_b === 1'b1);
    check("baud_ticks", 8'(ticks), 8'h04);
    check("baud_ticks_b", 8'(ticks_b), 8'h04);
    $display("test 7 done");
    test_done();
  end
endmodule
`default_nettype wire
